/* aoc_cfg.svh */
// Constants for the analog output calibration controller.
// Assumes inclusion by the package and the design module only.
`ifndef AOC_CFG_SVH
`define AOC_CFG_SVH
`define AOC_ADDR_OUT_LEVEL 8'h00
`define AOC_ADDR_RANGE_CFG 8'h04
`define AOC_ADDR_IN_RAW 8'h08
`define AOC_ADDR_IN_RES 8'h0c
`define AOC_ADDR_TRIM_GAIN 8'h10
`define AOC_ADDR_TRIM_ZERO 8'h14
`define AOC_ADDR_SAVE 8'h18
`define AOC_ADDR_STATUS 8'h1c
`define AOC_ADDR_OUT_CODE 8'h20
`define AOC_CODE_MAX 13'sh0fff
`define AOC_GAIN_DIV 32'sd10000
`define AOC_ZERO_LIM 8'sd100
`define AOC_CH_1 8'h01
`define AOC_CH_2 8'h02
`define AOC_RANGE_5V 8'h01
`define AOC_RANGE_10V 8'h02
`define AOC_RANGE_BIT_5V 1'b0
`define AOC_RANGE_BIT_10V 1'b1
`define AOC_MID_CODE 12'h800
`define AOC_LVL_CH_HI 31
`define AOC_LVL_CH_LO 24
`define AOC_CMD_CH_HI 15
`define AOC_CMD_CH_LO 8
`define AOC_CMD_RNG_HI 7
`define AOC_TRIM_IN_BIT 24
`define AOC_TRIM_CH_BIT 16
`define AOC_GAIN_HI 15
`define AOC_ZERO_HI 7
`define AOC_SAVE_GO_BIT 0
`endif

/* aoc_pkg.sv */
// Types for the analog output calibration controller.
// Assumes aoc_cfg.svh is on the include path.
`default_nettype none
`include "aoc_cfg.svh"
package aoc_pkg;
  typedef struct packed {
    logic signed [15:0] gain;
    logic signed [7:0] zero;
  } aoc_trim_t;
  typedef struct packed {
    logic [11:0] code;
    logic range_10v;
  } aoc_dac_t;
  typedef enum logic [1:0] {
    AOC_ST_RUN = 2'b00,
    AOC_ST_RESTART = 2'b01
  } aoc_state_t;
endpackage
`default_nettype wire

/* aoc_ctrl.sv */
// Analog output calibration controller: two DAC channels, two ADC paths.
// Assumes a single AHB-Lite master, word accesses, and a cold-boot
// reset; trims kept in a shadow store survive the block's self restart.
//
// Overview of operation
// - Two independent output channels, each with a 12-bit setpoint.
// - Output voltage is setpoint over 4096 of selected full scale.
// - A setpoint holds its channel until a new one is written or a reset or self restart clears it.
// - Range command: channel byte 01/02, range byte 01=5V, 02=10V.
// - Every channel starts in the 0 to 5V range after reset.
// - Setpoint is scaled by 1 + gain trim / 10000 before the DAC.
// - Output zero trim, -100..100, is added to the setpoint.
// - Input readings are scaled by 1 + input gain trim / 10000.
// - Input zero trim, -100..100, is added to each reading.
// - Saved trims take effect only after the next cold boot or self restart.
// - Restart-after-save option restarts the block after the save.
// - With zero trims code 2048 means 2.500V in and out in the 5V range, 5.000V out in the 10V range.
//
// The implementer's own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "aoc_cfg.svh"
module aoc_ctrl
  import aoc_pkg::*;
#(
  parameter int CH = 2,
  parameter int CW = 12
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [CW-1:0] adc_raw_0,
  input wire logic [CW-1:0] adc_raw_1,
  output aoc_dac_t dac_0,
  output aoc_dac_t dac_1,
  output logic restart_busy
);

  // ****************************************
  // Bus address phase capture
  // ****************************************
  logic wr_q;
  logic wr_d;
  logic rd_q;
  logic rd_d;
  logic [7:0] addr_q;
  logic [7:0] addr_d;
  wire logic take = hsel & hready & htrans[1];
  assign wr_d = take & hwrite;
  assign rd_d = take & ~hwrite;
  assign addr_d = take ? haddr[7:0] : addr_q;

  // Write strobes decoded from the data phase
  wire logic wr_lvl = wr_q && addr_q == `AOC_ADDR_OUT_LEVEL;
  wire logic wr_rng = wr_q && addr_q == `AOC_ADDR_RANGE_CFG;
  wire logic wr_gain = wr_q && addr_q == `AOC_ADDR_TRIM_GAIN;
  wire logic wr_zero = wr_q && addr_q == `AOC_ADDR_TRIM_ZERO;
  wire logic wr_save = wr_q && addr_q == `AOC_ADDR_SAVE;
  // Level word keeps its channel in the top byte, clear of the value bits
  wire logic [7:0] lvl_ch = hwdata[`AOC_LVL_CH_HI:`AOC_LVL_CH_LO];
  wire logic [CW-1:0] lvl_val = hwdata[CW-1:0];
  // Range command word: channel byte above range byte
  wire logic [7:0] chan_sel = hwdata[`AOC_CMD_CH_HI:`AOC_CMD_CH_LO];
  wire logic [7:0] range_sel = hwdata[`AOC_CMD_RNG_HI:0];
  // Trim word: bit 24 picks input (1) or output (0) trims, bit 16 the chan
  wire logic trim_in = hwdata[`AOC_TRIM_IN_BIT];
  wire logic trim_ch = hwdata[`AOC_TRIM_CH_BIT];
  wire logic [15:0] gain_val = hwdata[`AOC_GAIN_HI:0];
  wire logic [7:0] zero_val = hwdata[`AOC_ZERO_HI:0];
  // Save word: low bit asks for a restart once the write has landed
  wire logic save_go = hwdata[`AOC_SAVE_GO_BIT];

  // ****************************************
  // Setpoints and ranges
  // ****************************************
  logic [CW-1:0] lvl_q [CH];
  logic rng_q [CH];
  // Saved trims (nonvolatile shadow) and live trims latched at boot
  aoc_trim_t sv_out_q [CH];
  aoc_trim_t sv_in_q [CH];
  aoc_trim_t lv_out_q [CH];
  aoc_trim_t lv_in_q [CH];
  aoc_state_t st_q;
  aoc_state_t st_d;
  logic boot_q;

  // ****************************************
  // Correction arithmetic
  // ****************************************
  // 32-bit signed math: full code times the widest gain trim stays in range
  // Division truncates toward zero, so tiny trims may not move a code
  function automatic logic [CW-1:0] corr(input logic [CW-1:0] v,
                                         input aoc_trim_t t);
    logic signed [31:0] p;
    logic signed [31:0] s;
    p = $signed(32'(v));
    s = p + (p * $signed(32'(t.gain))) / `AOC_GAIN_DIV;
    s = s + $signed(32'(t.zero));
    if (s < 0) begin
      s = 0;
    end else if (s > 32'(`AOC_CODE_MAX)) begin
      s = 32'(`AOC_CODE_MAX);
    end
    corr = s[CW-1:0];
  endfunction

  function automatic logic signed [7:0] zlim(input logic [7:0] z);
    logic signed [7:0] r;
    r = $signed(z);
    if (r > `AOC_ZERO_LIM) begin
      r = `AOC_ZERO_LIM;
    end else if (r < -`AOC_ZERO_LIM) begin
      r = -`AOC_ZERO_LIM;
    end
    zlim = r;
  endfunction

  logic [CW-1:0] out_code [CH];
  logic [CW-1:0] in_res [CH];
  wire logic [CW-1:0] adc_raw [CH];
  assign adc_raw[0] = adc_raw_0;
  assign adc_raw[1] = adc_raw_1;
  // code maps linearly onto the selected full scale
  // zero trims pass mid code 2048 through unchanged
  always_comb begin
    for (int i = 0; i < CH; i++) begin
      out_code[i] = corr(lvl_q[i], lv_out_q[i]);
      in_res[i] = corr(adc_raw[i], lv_in_q[i]);
    end
  end

  // ****************************************
  // Restart sequencer
  // ****************************************
  // restart once the save transfer completes
  // Restart lasts one cycle; the two unused codes fall back to run
  always_comb begin
    st_d = AOC_ST_RUN;
    unique case (st_q)
      AOC_ST_RUN: begin
        if (wr_save && save_go) begin
          st_d = AOC_ST_RESTART;
        end
      end
      AOC_ST_RESTART: begin
        st_d = AOC_ST_RUN;
      end
      default: begin
        st_d = AOC_ST_RUN;
      end
    endcase
  end
  wire logic soft_rst = st_q == AOC_ST_RESTART;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= 8'h00;
      st_q <= AOC_ST_RUN;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      addr_q <= addr_d;
      st_q <= st_d;
    end
  end

  // Setpoints and ranges clear on cold boot and on self restart
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < CH; i++) begin
      if (!reset_n || soft_rst) begin
        lvl_q[i] <= '0;
        rng_q[i] <= `AOC_RANGE_BIT_5V;
      end else begin
        if (wr_lvl && lvl_ch == 8'(i + 1)) begin
          lvl_q[i] <= lvl_val;
        end
        if (wr_rng && chan_sel == 8'(i + 1)) begin
          if (range_sel == `AOC_RANGE_5V) begin
            rng_q[i] <= `AOC_RANGE_BIT_5V;
          end else if (range_sel == `AOC_RANGE_10V) begin
            rng_q[i] <= `AOC_RANGE_BIT_10V;
          end
        end
      end
    end
  end

  // ****************************************
  // Saved and live trims
  // ****************************************
  // Saved store is nonvolatile: untouched by any reset
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < CH; i++) begin
      if (wr_gain && trim_ch == 1'(i)) begin
        if (trim_in) begin
          sv_in_q[i].gain <= gain_val;
        end else begin
          sv_out_q[i].gain <= gain_val;
        end
      end
      if (wr_zero && trim_ch == 1'(i)) begin
        if (trim_in) begin
          sv_in_q[i].zero <= zlim(zero_val);
        end else begin
          sv_out_q[i].zero <= zlim(zero_val);
        end
      end
    end
  end

  // live trims load only on boot
  // The reload lands one cycle after boot, so outputs settle a cycle later
  always_ff @(posedge clk_sys) begin
    boot_q <= !reset_n || soft_rst;
    for (int i = 0; i < CH; i++) begin
      if (boot_q) begin
        lv_out_q[i] <= sv_out_q[i];
        lv_in_q[i] <= sv_in_q[i];
      end
    end
  end

  // ****************************************
  // Read mux and outputs
  // ****************************************
  wire logic rch = hwdata[0];
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    unique case (addr_q)
      `AOC_ADDR_OUT_LEVEL:
        rd_mux = {4'h0, lvl_q[1], 4'h0, lvl_q[0]};
      `AOC_ADDR_RANGE_CFG:
        rd_mux = {30'h0, rng_q[1], rng_q[0]};
      `AOC_ADDR_IN_RAW:
        rd_mux = {4'h0, adc_raw[1], 4'h0, adc_raw[0]};
      `AOC_ADDR_IN_RES:
        rd_mux = {4'h0, in_res[1], 4'h0, in_res[0]};
      `AOC_ADDR_TRIM_GAIN:
        rd_mux = {lv_out_q[1].gain, lv_out_q[0].gain};
      `AOC_ADDR_TRIM_ZERO:
        rd_mux = {lv_in_q[1].zero, lv_in_q[0].zero,
                  lv_out_q[1].zero, lv_out_q[0].zero};
      `AOC_ADDR_STATUS:
        rd_mux = {31'h0, soft_rst};
      `AOC_ADDR_OUT_CODE:
        rd_mux = {4'h0, out_code[1], 4'h0, out_code[0]};
      default:
        rd_mux = 32'h00000000;
    endcase
  end

  // ****************************************
  // Bus response and converter registers
  // ****************************************
  // Read data registered: one wait state per read keeps hrdata on a flop
  logic rd_wait_q;
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      rd_wait_q <= 1'b0;
      dac_0 <= '{code: '0, range_10v: `AOC_RANGE_BIT_5V};
      dac_1 <= '{code: '0, range_10v: `AOC_RANGE_BIT_5V};
      restart_busy <= 1'b0;
    end else begin
      rd_wait_q <= rd_d;
      hreadyout <= ~rd_d;
      if (rd_q) begin
        hrdata <= rd_mux;
      end
      dac_0 <= '{code: out_code[0], range_10v: rng_q[0]};
      dac_1 <= '{code: out_code[1], range_10v: rng_q[1]};
      // Only a self restart shows busy; the cold-boot reload stays silent
      restart_busy <= soft_rst | (boot_q & restart_busy);
    end
  end

  logic unused_ok;
  assign unused_ok = &{1'b0, rch, hsize, rd_wait_q, haddr[31:8], htrans[0]};

endmodule // aoc_ctrl
`default_nettype wire

/* aoc_dac_model.sv */
// Converter model: code and range bit to output millivolts.
// Assumes it watches one registered converter port.
`timescale 1ns/1ps
`default_nettype none
module aoc_dac_model
  import aoc_pkg::*;
(
  input wire aoc_dac_t dac,
  output logic [15:0] mv
);
  // scaled output
  // Truncates like a real ladder: 1/4096 of full scale per code
  assign mv = 16'((32'(dac.code) *
    (dac.range_10v ? 32'h2710 : 32'h1388)) >> 12);
endmodule // aoc_dac_model
`default_nettype wire

/* aoc_ctrl_props.sv */
// Checker on the controller's bus and converter ports.
// Assumes one master with hready fed from hreadyout.
`timescale 1ns/1ps
`default_nettype none
module aoc_ctrl_props
  import aoc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire aoc_dac_t dac_0,
  input wire aoc_dac_t dac_1,
  input wire logic restart_busy
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire ap = hsel && hreadyout && htrans[1];
  wire [7:0] a = haddr[7:0];
  wire moves = ap && hwrite && (a == 8'h00 || a == 8'h04);
  logic [3:0] ev_q;
  logic [3:0] rs_q;
  // Boot reload may move codes, so the window starts open
  always_ff @(posedge clk_sys) begin
    ev_q <= reset_n ? {ev_q[2:0], moves || restart_busy} : 4'hf;
    rs_q <= reset_n ? {rs_q[2:0], ap && hwrite && a == 8'h18} : 4'h0;
  end
  property p_hold0; !$stable(dac_0) |-> |ev_q; endproperty
  a_hold0: assert property (p_hold0) else $error("dac_0 moved");
  property p_hold1; !$stable(dac_1) |-> |ev_q; endproperty
  a_hold1: assert property (p_hold1) else $error("dac_1 moved");
  property p_rng; !$past(reset_n) |-> !dac_0.range_10v && !dac_1.range_10v;
  endproperty
  a_rng: assert property (p_rng) else $error("range not 5V");
  property p_busy; $rose(restart_busy) |-> restart_busy[*2] ##1 !restart_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("restart length");
  property p_cause; $rose(restart_busy) |-> |rs_q; endproperty
  a_cause: assert property (p_cause) else $error("stray restart");
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("bad response");
  property p_rdw; ap && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
  a_rdw: assert property (p_rdw) else $error("read wait");
  property p_wrw; ap && hwrite |=> hreadyout; endproperty
  a_wrw: assert property (p_wrw) else $error("write wait");
  c_read: cover property (ap && !hwrite);
  c_rst: cover property ($rose(restart_busy));
  c_10v: cover property (dac_1.range_10v);
endmodule // aoc_ctrl_props
bind aoc_ctrl aoc_ctrl_props i_aoc_ctrl_props(.clk_sys(clk_sys),
  .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hreadyout(hreadyout), .hresp(hresp), .dac_0(dac_0),
  .dac_1(dac_1), .restart_busy(restart_busy));
`default_nettype wire

/* aoc_ctrl_bench.sv */
// Bench: bus tasks, trim table, range commands, second channel.
// Assumes the design package and converter model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module aoc_ctrl_bench
  import aoc_pkg::*;
;
  localparam logic [15:0] tg [5] = '{16'h0, 16'h51, 16'h51, 16'hffc4, 16'h0};
  localparam logic [7:0] tz [5] = '{8'h0, 8'h05, 8'h05, 8'h0, 8'h9c};
  localparam logic [11:0] lv [5] =
    '{12'h800, 12'h800, 12'hfff, 12'h800, 12'h32};
  localparam logic [11:0] ex [5] =
    '{12'h800, 12'h815, 12'hfff, 12'h7f4, 12'h0};
  localparam logic [15:0] rc [4] = '{16'h0102, 16'h0302, 16'h0202, 16'h0101};
  localparam logic [1:0] rx [4] = '{2'h1, 2'h1, 2'h3, 2'h2};
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [11:0] adc_raw_0 = 12'h0;
  logic [11:0] adc_raw_1 = 12'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic restart_busy;
  aoc_dac_t dac_0;
  aoc_dac_t dac_1;
  logic [15:0] mv_0;
  logic [31:0] rd;
  logic [11:0] prev;
  int err_count = 0;
  int n_tests = 0;
  initial forever #5 clk_sys = ~clk_sys;
  aoc_ctrl i_aoc_ctrl(.clk_sys(clk_sys), .reset_n(reset_n), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .adc_raw_0(adc_raw_0),
    .adc_raw_1(adc_raw_1), .dac_0(dac_0), .dac_1(dac_1),
    .restart_busy(restart_busy));
  aoc_dac_model i_aoc_dac_model(.dac(dac_0), .mv(mv_0));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (hreadyout !== 1'b1 && k < 20);
    if (hreadyout !== 1'b1) begin
      $display("mismatch hready exp 1 got %b", hreadyout);
      err_count++;
      finish_test();
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic chk(input string s, input logic [31:0] e,
    input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask
  // Both paths of one channel get the same trims
  task automatic trims(input logic [15:0] g, input logic [7:0] z,
    input logic c);
    for (int s = 0; s < 2; s++) begin
      xfer(1'b1, 8'h10, {7'h0, s[0], 7'h0, c, g});
      xfer(1'b1, 8'h14, {7'h0, s[0], 7'h0, c, 8'h0, z});
    end
  endtask
  task automatic restart();
    xfer(1'b1, 8'h18, 32'h1);
    repeat (6) @(posedge clk_sys);
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    for (int c = 0; c < 2; c++) trims(16'h0, 8'h0, c[0]);
    restart();
    prev = 12'h0;
    for (int i = 0; i < 5; i++) begin
      trims(tg[i], tz[i], 1'b0);
      chk("held code", {20'h0, prev}, {20'h0, dac_0.code});
      restart();
      adc_raw_0 <= lv[i];
      xfer(1'b1, 8'h00, {8'h01, 12'h0, lv[i]});
      repeat (3) @(posedge clk_sys);
      chk("out code", {20'h0, ex[i]}, {20'h0, dac_0.code});
      if (i == 0) chk("millivolts", 32'h9c4, {16'h0, mv_0});
      xfer(1'b0, 8'h0c, 32'h0);
      chk("in code", {20'h0, ex[i]}, {20'h0, rd[11:0]});
      prev = ex[i];
    end
    $display("test trims done");
    // Channel 2 output zero trim above the limit must clamp to +100
    xfer(1'b1, 8'h14, {16'h0001, 8'h0, 8'h7f});
    restart();
    xfer(1'b0, 8'h14, 32'h0);
    chk("zero trims", 32'h009c649c, rd);
    xfer(1'b0, 8'h20, 32'h0);
    chk("out codes", 32'h00640000, rd);
    $display("test zero clamp done");
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, 8'h04, {16'h0, rc[i]});
      xfer(1'b0, 8'h04, 32'h0);
      chk("range", {30'h0, rx[i]}, {30'h0, rd[1:0]});
      chk("dac range", {30'h0, rx[i]}, {30'h0, dac_1.range_10v,
        dac_0.range_10v});
    end
    $display("test range done");
    adc_raw_1 <= 12'h123;
    xfer(1'b1, 8'h00, {8'h02, 12'h0, 12'hfff});
    repeat (3) @(posedge clk_sys);
    chk("ch2 code", 32'hfff, {20'h0, dac_1.code});
    chk("ch1 code", 32'h0, {20'h0, dac_0.code});
    xfer(1'b0, 8'h0c, 32'h0);
    chk("ch2 in", 32'h123, {20'h0, rd[27:16]});
    xfer(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("test channel two done");
    reset_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    xfer(1'b0, 8'h04, 32'h0);
    chk("boot range", 32'h0, {30'h0, rd[1:0]});
    $display("test reboot done");
    finish_test();
  end
endmodule // aoc_ctrl_bench
`default_nettype wire
